// [core/lpc_pkg.sv]
// constants, types and field layouts of the listen and transmit power register bank
package lpc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_OPMODE        = 8'h01;
    localparam logic [7:0] ADDR_OSC           = 8'h0A;
    localparam logic [7:0] ADDR_LISTEN_TIMING = 8'h0D;
    localparam logic [7:0] ADDR_IDLE_MULT     = 8'h0E;
    localparam logic [7:0] ADDR_RX_MULT       = 8'h0F;
    localparam logic [7:0] ADDR_REVISION      = 8'h10;
    localparam logic [7:0] ADDR_AMP_LEVEL     = 8'h11;
    localparam logic [7:0] ADDR_AMP_RAMP      = 8'h12;
    localparam logic [7:0] ADDR_OVERCURRENT   = 8'h13;

    // field positions
    localparam int OPM_LISTEN_BIT   = 6;
    localparam int OPM_MODE_LSB     = 2;
    localparam int OSC_TRIGGER_BIT  = 7;
    localparam int OSC_FINISHED_BIT = 6;
    localparam int LT_IDLE_LSB      = 6;
    localparam int LT_RX_LSB        = 4;
    localparam int LT_RULE_BIT      = 3;
    localparam int LT_EXIT_LSB      = 1;

    // reset values and write masks
    localparam logic [7:0] OPM_RESET     = 8'h04;
    localparam logic [7:0] OPM_WMASK     = 8'h5C;
    localparam logic [5:0] OSC_LOW_BITS  = 6'h01;
    localparam logic [7:0] LT_RESET      = 8'h52;
    localparam logic [7:0] LT_WMASK      = 8'hFE;
    localparam logic [7:0] IDLE_MULT_RST = 8'hF5;
    localparam logic [7:0] RX_MULT_RST   = 8'h20;
    localparam logic [7:0] LEVEL_RESET   = 8'h9F;
    localparam logic [7:0] RAMP_RESET    = 8'h09;
    localparam logic [7:0] RAMP_WMASK    = 8'h0F;
    localparam logic [7:0] OCP_RESET     = 8'h1A;
    localparam logic [7:0] OCP_WMASK     = 8'h1F;

    // wake exit actions
    localparam logic [1:0] EXIT_STAY    = 2'h0;
    localparam logic [1:0] EXIT_TO_MODE = 2'h1;
    localparam logic [1:0] EXIT_RESUME  = 2'h2;

    // time unit codes and timing
    localparam logic [1:0] UNIT_MID      = 2'h2;
    localparam logic [1:0] UNIT_LONG     = 2'h3;
    localparam int CLK_PERIOD_NS         = 8;
    localparam int UNIT_SHORT_NS         = 64000;
    localparam int UNIT_MID_NS           = 4100000;
    localparam int UNIT_LONG_NS          = 262000000;
    localparam int UNIT_SHORT_CYC        = UNIT_SHORT_NS / CLK_PERIOD_NS;
    localparam int UNIT_MID_CYC          = UNIT_MID_NS / CLK_PERIOD_NS;
    localparam int UNIT_LONG_CYC         = UNIT_LONG_NS / CLK_PERIOD_NS;
    localparam int CAL_CYC               = 2000;
    localparam int UNIT_W                = 26;

    typedef enum logic [2:0] {
        MODE_SLEEP   = 3'h0,
        MODE_STANDBY = 3'h1,
        MODE_FSYNTH  = 3'h2,
        MODE_TX      = 3'h3,
        MODE_RX      = 3'h4
    } lpc_op_mode_type;

    typedef enum logic [2:0] {
        LST_OFF  = 3'h0,
        LST_IDLE = 3'h1,
        LST_RX   = 3'h2,
        LST_HOLD = 3'h3,
        LST_STOP = 3'h4
    } lpc_listen_state_type;

    // status from the receive path, same clock
    typedef struct packed {
        logic above_strength_limit;
        logic pattern_match;
        logic payload_complete_flag;
        logic rx_timeout;
    } lpc_rx_status_type;

    // transmitter settings driven to the analog side
    typedef struct packed {
        logic       main_amp_enable;
        logic       boost_amp_a_enable;
        logic       boost_amp_b_enable;
        logic [4:0] tx_power_level;
        logic [3:0] amp_ramp_code;
        logic       overcurrent_guard_enable;
        logic [3:0] overcurrent_limit_trim;
    } lpc_amp_cfg_type;

endpackage

// [core/lpc_listen_power_regs.sv]
// listen cycle sequencer with transmit power configuration registers
module lpc_listen_power_regs #(
    parameter int UNIT_SHORT_CYCLES = lpc_pkg::UNIT_SHORT_CYC,
    parameter int UNIT_MID_CYCLES   = lpc_pkg::UNIT_MID_CYC,
    parameter int UNIT_LONG_CYCLES  = lpc_pkg::UNIT_LONG_CYC,
    parameter int CAL_CYCLES        = lpc_pkg::CAL_CYC,
    parameter logic [7:0] REVISION  = 8'h31 // arbitrary value
) (
    // clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    // register port
    input  wire logic [7:0]                addr_i,
    input  wire logic [7:0]                wr_data_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic [7:0]                     rd_data_o,
    // receive path status
    input  wire lpc_pkg::lpc_rx_status_type rx_status_i,
    // sequencer outputs
    output lpc_pkg::lpc_op_mode_type       cur_mode_o,
    output logic                           listen_active_o,
    output logic                           fifo_flush_o,
    output logic                           osc_cal_busy_o,
    // transmitter settings
    output lpc_pkg::lpc_amp_cfg_type       amp_cfg_o
);
    import lpc_pkg::*;

    logic [7:0]           level_reg;
    logic [3:0]           ramp_reg;
    logic [4:0]           ocp_reg;
    logic [1:0]           idle_unit_reg;
    logic [1:0]           rx_unit_reg;
    logic                 accept_rule_reg;
    logic [1:0]           exit_action_reg;
    logic [7:0]           idle_mult_reg;
    logic [7:0]           rx_mult_reg;
    logic                 listen_en_reg;
    lpc_op_mode_type      mode_req_reg;
    lpc_op_mode_type      cur_mode_reg;
    lpc_op_mode_type      cur_mode_next;
    lpc_listen_state_type lst_reg;
    lpc_listen_state_type lst_next;
    logic                 flush_pend_reg;
    logic                 flush_pend_next;
    logic                 fifo_flush_reg;
    logic                 fifo_flush_next;
    logic                 listen_active_reg;
    logic                 cal_busy_reg;
    logic [11:0]          cal_cnt_reg;
    logic [UNIT_W-1:0]    unit_cnt_reg;
    logic [7:0]           mult_cnt_reg;
    logic [7:0]           rd_data_reg;
    logic [7:0]           rd_value;
    logic [UNIT_W-1:0]    unit_len;
    logic [7:0]           phase_mult;
    logic                 phase_run;
    logic                 unit_tick;
    logic                 phase_done;
    logic                 accept;
    logic                 rx_end;
    logic                 wr_opmode;
    logic                 cal_start;

    // code 00 is reserved; treated like the shortest unit so timing never stalls
    function automatic logic [UNIT_W-1:0] unit_last(input logic [1:0] code);
        case (code)
            UNIT_MID:  unit_last = UNIT_W'(UNIT_MID_CYCLES - 1);
            UNIT_LONG: unit_last = UNIT_W'(UNIT_LONG_CYCLES - 1);
            default:   unit_last = UNIT_W'(UNIT_SHORT_CYCLES - 1);
        endcase
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = wr_i && (addr_i == a);
    endfunction

    assign wr_opmode = wr_hit(ADDR_OPMODE);
    assign cal_start = wr_hit(ADDR_OSC) && wr_data_i[OSC_TRIGGER_BIT]
                       && (cur_mode_reg == MODE_STANDBY) && !cal_busy_reg;

    // mode request and listen enable
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_req_reg  <= MODE_STANDBY;
            listen_en_reg <= 1'b0;
        end else if (wr_opmode) begin
            mode_req_reg  <= lpc_op_mode_type'(wr_data_i[OPM_MODE_LSB +: 3]);
            listen_en_reg <= wr_data_i[OPM_LISTEN_BIT];
        end
    end

    // listen timing fields
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            idle_unit_reg   <= LT_RESET[LT_IDLE_LSB +: 2];
            rx_unit_reg     <= LT_RESET[LT_RX_LSB +: 2];
            accept_rule_reg <= LT_RESET[LT_RULE_BIT];
            exit_action_reg <= LT_RESET[LT_EXIT_LSB +: 2];
            idle_mult_reg   <= IDLE_MULT_RST;
            rx_mult_reg     <= RX_MULT_RST;
        end else begin
            if (wr_hit(ADDR_LISTEN_TIMING)) begin
                idle_unit_reg   <= wr_data_i[LT_IDLE_LSB +: 2];
                rx_unit_reg     <= wr_data_i[LT_RX_LSB +: 2];
                accept_rule_reg <= wr_data_i[LT_RULE_BIT];
                exit_action_reg <= wr_data_i[LT_EXIT_LSB +: 2];
            end
            if (wr_hit(ADDR_IDLE_MULT))
                idle_mult_reg <= wr_data_i;
            if (wr_hit(ADDR_RX_MULT))
                rx_mult_reg <= wr_data_i;
        end
    end

    // transmitter settings
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            level_reg <= LEVEL_RESET;
            ramp_reg  <= RAMP_RESET[3:0];
            ocp_reg   <= OCP_RESET[4:0];
        end else begin
            if (wr_hit(ADDR_AMP_LEVEL))
                level_reg <= wr_data_i;
            if (wr_hit(ADDR_AMP_RAMP))
                ramp_reg <= wr_data_i[3:0];
            if (wr_hit(ADDR_OVERCURRENT))
                ocp_reg <= wr_data_i[4:0];
        end
    end

    // oscillator calibration; listen timing waits for it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_busy_reg <= 1'b0;
            cal_cnt_reg  <= 12'h000;
        end else if (cal_start) begin
            cal_busy_reg <= 1'b1;
            cal_cnt_reg  <= 12'(CAL_CYCLES - 1);
        end else if (cal_busy_reg) begin
            if (cal_cnt_reg == 12'h000)
                cal_busy_reg <= 1'b0;
            else
                cal_cnt_reg <= cal_cnt_reg - 12'h001;
        end
    end

    // phase timing: multiplier counts whole time units
    assign unit_len   = unit_last(lst_reg == LST_RX ? rx_unit_reg : idle_unit_reg);
    assign phase_mult = (lst_reg == LST_RX) ? rx_mult_reg : idle_mult_reg;
    assign phase_run  = ((lst_reg == LST_IDLE) || (lst_reg == LST_RX)) && !cal_busy_reg;
    assign unit_tick  = phase_run && (unit_cnt_reg == unit_len);
    // a zero multiplier still lasts one unit
    assign phase_done = unit_tick && ({1'b0, mult_cnt_reg} + 9'h001 >= {1'b0, phase_mult});

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            unit_cnt_reg <= '0;
            mult_cnt_reg <= 8'h00;
        end else if (lst_next != lst_reg || !phase_run) begin
            unit_cnt_reg <= '0;
            mult_cnt_reg <= 8'h00;
        end else if (unit_tick) begin
            unit_cnt_reg <= '0;
            mult_cnt_reg <= mult_cnt_reg + 8'h01;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + UNIT_W'(1);
        end
    end

    assign accept = rx_status_i.above_strength_limit
                    && (!accept_rule_reg || rx_status_i.pattern_match);
    assign rx_end = rx_status_i.payload_complete_flag || rx_status_i.rx_timeout;

    // listen sequencer
    always_comb begin
        lst_next        = lst_reg;
        cur_mode_next   = cur_mode_reg;
        flush_pend_next = flush_pend_reg;
        fifo_flush_next = 1'b0;
        if (lst_reg != LST_OFF && !listen_en_reg) begin
            lst_next      = LST_OFF;
            cur_mode_next = mode_req_reg;
        end else begin
            case (lst_reg)
                LST_OFF: begin
                    cur_mode_next = mode_req_reg;
                    if (listen_en_reg && !cal_busy_reg)
                        lst_next = LST_IDLE;
                end
                LST_IDLE: begin
                    cur_mode_next = mode_req_reg;
                    if (phase_done) begin
                        lst_next        = LST_RX;
                        cur_mode_next   = MODE_RX;
                        fifo_flush_next = flush_pend_reg;
                        flush_pend_next = 1'b0;
                    end
                end
                LST_RX: begin
                    if (accept) begin
                        // reserved code 11 behaves like 00
                        if (exit_action_reg == EXIT_TO_MODE || exit_action_reg == EXIT_RESUME)
                            lst_next = LST_HOLD;
                        else
                            lst_next = LST_STOP;
                    end else if (phase_done) begin
                        lst_next      = LST_IDLE;
                        cur_mode_next = mode_req_reg;
                    end
                end
                LST_HOLD: begin
                    if (rx_end) begin
                        cur_mode_next = mode_req_reg;
                        if (exit_action_reg == EXIT_TO_MODE) begin
                            lst_next = LST_STOP;
                        end else begin
                            lst_next        = LST_IDLE;
                            flush_pend_next = 1'b1;
                        end
                    end
                end
                LST_STOP: begin
                    // held until software drops the listen enable
                    lst_next = LST_STOP;
                end
                default: begin
                    lst_next      = LST_OFF;
                    cur_mode_next = mode_req_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lst_reg        <= LST_OFF;
            cur_mode_reg   <= MODE_STANDBY;
            flush_pend_reg <= 1'b0;
            fifo_flush_reg <= 1'b0;
            listen_active_reg <= 1'b0;
        end else begin
            lst_reg        <= lst_next;
            cur_mode_reg   <= cur_mode_next;
            flush_pend_reg <= flush_pend_next;
            fifo_flush_reg <= fifo_flush_next;
            // taken from the next state so the flop tracks lst_reg with no lag
            listen_active_reg <= (lst_next != LST_OFF) && (lst_next != LST_STOP);
        end
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        case (addr_i)
            ADDR_OPMODE:        rd_value = {1'b0, listen_en_reg, 1'b0, cur_mode_reg, 2'b00};
            ADDR_OSC:           rd_value = {1'b0, !cal_busy_reg, OSC_LOW_BITS};
            ADDR_LISTEN_TIMING: rd_value = {idle_unit_reg, rx_unit_reg, accept_rule_reg,
                                            exit_action_reg, 1'b0};
            ADDR_IDLE_MULT:     rd_value = idle_mult_reg;
            ADDR_RX_MULT:       rd_value = rx_mult_reg;
            ADDR_REVISION:      rd_value = REVISION;
            ADDR_AMP_LEVEL:     rd_value = level_reg;
            ADDR_AMP_RAMP:      rd_value = {4'h0, ramp_reg};
            ADDR_OVERCURRENT:   rd_value = {3'h0, ocp_reg};
            default:            rd_value = 8'h00;
        endcase
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            rd_data_reg <= 8'h00;
        else
            rd_data_reg <= rd_i ? rd_value : 8'h00;
    end

    assign rd_data_o       = rd_data_reg;
    assign cur_mode_o      = cur_mode_reg;
    assign listen_active_o = listen_active_reg;
    assign fifo_flush_o    = fifo_flush_reg;
    assign osc_cal_busy_o  = cal_busy_reg;
    assign amp_cfg_o.main_amp_enable          = level_reg[7];
    assign amp_cfg_o.boost_amp_a_enable       = level_reg[6];
    assign amp_cfg_o.boost_amp_b_enable       = level_reg[5];
    assign amp_cfg_o.tx_power_level           = level_reg[4:0];
    assign amp_cfg_o.amp_ramp_code            = ramp_reg;
    assign amp_cfg_o.overcurrent_guard_enable = ocp_reg[4];
    assign amp_cfg_o.overcurrent_limit_trim   = ocp_reg[3:0];

endmodule // lpc_listen_power_regs

// [verif/lpc_listen_power_regs_monitor.sv]
// port-level assertions for the listen and transmit power register bank
module lpc_listen_power_regs_monitor
    import lpc_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h31 // arbitrary value
) (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    // register port
    input  wire logic [7:0]                 addr_i,
    input  wire logic [7:0]                 wr_data_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    input  wire logic [7:0]                 rd_data_o,
    // sequencer and settings
    input  wire lpc_pkg::lpc_rx_status_type rx_status_i,
    input  wire lpc_pkg::lpc_op_mode_type   cur_mode_o,
    input  wire logic                       listen_active_o,
    input  wire logic                       fifo_flush_o,
    input  wire logic                       osc_cal_busy_o,
    input  wire lpc_pkg::lpc_amp_cfg_type   amp_cfg_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_unmapped_zero: assert property (rd_i && addr_i > ADDR_OVERCURRENT |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    a_revision_read: assert property (rd_i && addr_i == ADDR_REVISION |=> rd_data_o == REVISION)
        else $error("revision read wrong");
    a_level_write: assert property (wr_i && addr_i == ADDR_AMP_LEVEL |=>
        {amp_cfg_o.main_amp_enable, amp_cfg_o.boost_amp_a_enable, amp_cfg_o.boost_amp_b_enable,
         amp_cfg_o.tx_power_level} == $past(wr_data_i))
        else $error("amplifier level write not applied");
    a_ramp_write: assert property (wr_i && addr_i == ADDR_AMP_RAMP |=>
        amp_cfg_o.amp_ramp_code == $past(wr_data_i[3:0]))
        else $error("ramp write not applied");
    a_guard_write: assert property (wr_i && addr_i == ADDR_OVERCURRENT |=>
        {amp_cfg_o.overcurrent_guard_enable, amp_cfg_o.overcurrent_limit_trim} == $past(wr_data_i[4:0]))
        else $error("overcurrent write not applied");
    a_amp_hold: assert property (!(wr_i && addr_i inside {[ADDR_AMP_LEVEL:ADDR_OVERCURRENT]}) |=>
        $stable(amp_cfg_o))
        else $error("amplifier settings changed without write");
    a_mode_readback: assert property (rd_i && addr_i == ADDR_OPMODE |=>
        rd_data_o[4:2] == $past(cur_mode_o))
        else $error("mode read does not show active mode");
    // enable drops at the write edge, the sequencer leaves its state one edge later
    a_listen_clear: assert property (wr_i && addr_i == ADDR_OPMODE && !wr_data_i[OPM_LISTEN_BIT] |->
        ##2 !listen_active_o)
        else $error("listen still active after clear");
    a_cal_start: assert property (wr_i && addr_i == ADDR_OSC && wr_data_i[7] &&
        cur_mode_o == MODE_STANDBY && !osc_cal_busy_o |=> osc_cal_busy_o)
        else $error("calibration did not start");
    a_flush_single: assert property (fifo_flush_o |=> !fifo_flush_o)
        else $error("flush pulse longer than one cycle");
endmodule // lpc_listen_power_regs_monitor

// [verif/lpc_listen_power_regs_tb_top.sv]
// self-checking bench for the listen and transmit power register bank
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end

module lpc_listen_power_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lpc_pkg::*;

    localparam logic [7:0] REV   = 8'h5A; // arbitrary value
    localparam int         LIMIT = 20000;

    logic              mclk;
    logic              rst;
    logic              wr;
    logic              rd;
    logic [7:0]        addr;
    logic [7:0]        wr_data;
    logic [7:0]        rd_data;
    lpc_rx_status_type rx_st;
    lpc_op_mode_type   cur_mode;
    logic              listen_act;
    logic              flush;
    logic              cal_busy;
    lpc_amp_cfg_type   amp_cfg;
    int                bad_count;
    int                compares;
    int                cyc;
    int                n;
    // offsets, reset values and writable masks, last entry unmapped
    logic [7:0] ra[10] = '{8'h01, 8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20};
    logic [7:0] rv[10] = '{8'h04, 8'h41, 8'h52, 8'hF5, 8'h20, REV, 8'h9F, 8'h09, 8'h1A, 8'h00};
    logic [7:0] wm[10] = '{8'h00, 8'h00, 8'hFE, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h0F, 8'h1F, 8'h00};
    int         un[4]  = '{4, 4, 8, 16};

    lpc_listen_power_regs #(.UNIT_SHORT_CYCLES(4), .UNIT_MID_CYCLES(8), .UNIT_LONG_CYCLES(16),
        .CAL_CYCLES(10), .REVISION(REV)) uut (
        .mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd),
        .rd_data_o(rd_data), .rx_status_i(rx_st), .cur_mode_o(cur_mode), .listen_active_o(listen_act),
        .fifo_flush_o(flush), .osc_cal_busy_o(cal_busy), .amp_cfg_o(amp_cfg));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic results();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            $display("BAD %0t timeout", $time);
            results();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        `CHK(rd_data, exp)
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic set_rx(input logic [3:0] v);
        @(posedge mclk);
        rx_st <= lpc_rx_status_type'(v);
    endtask

    // n counts cycles until the mode shows up
    task automatic wait_mode(input lpc_op_mode_type m, input int lim);
        #1;
        n = 0;
        while (cur_mode !== m && n < lim) begin
            tick(1);
            n++;
        end
        `CHK(cur_mode, m)
    endtask

    task automatic listen_go(input logic [7:0] lt, input logic [7:0] mult);
        wr_reg(ADDR_LISTEN_TIMING, lt);
        wr_reg(ADDR_IDLE_MULT, mult);
        wr_reg(ADDR_RX_MULT, mult);
        wr_reg(ADDR_OPMODE, 8'h44);
    endtask

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        rx_st = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rd_chk(ra[i], rv[i]);
        for (int i = 2; i < 10; i++) begin
            wr_reg(ra[i], 8'hFF);
            rd_chk(ra[i], (i == 5) ? REV : wm[i]);
            wr_reg(ra[i], 8'h00);
            rd_chk(ra[i], (i == 5) ? REV : 8'h00);
        end
        $display("test register access done");

        wr_reg(ADDR_AMP_LEVEL, 8'h65);
        #1;
        `CHK({amp_cfg.main_amp_enable, amp_cfg.boost_amp_a_enable, amp_cfg.boost_amp_b_enable}, 3'b011)
        `CHK(amp_cfg.tx_power_level, 5'h05)
        wr_reg(ADDR_AMP_RAMP, 8'hEC);
        wr_reg(ADDR_OVERCURRENT, 8'hEB);
        #1;
        `CHK(amp_cfg.amp_ramp_code, 4'hC)
        `CHK(amp_cfg.overcurrent_guard_enable, 1'b0)
        `CHK(amp_cfg.overcurrent_limit_trim, 4'hB)
        $display("test amplifier settings done");

        wr_reg(ADDR_OSC, 8'h80);
        #1;
        `CHK(cal_busy, 1'b1)
        rd_chk(ADDR_OSC, 8'h01);
        n = 0;
        while (cal_busy === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        rd_chk(ADDR_OSC, 8'h41);
        wr_reg(ADDR_OPMODE, 8'h00);
        tick(1);
        `CHK(cur_mode, MODE_SLEEP)
        rd_chk(ADDR_OPMODE, 8'h00);
        wr_reg(ADDR_OSC, 8'h80);
        tick(2);
        `CHK(cal_busy, 1'b0)
        wr_reg(ADDR_OPMODE, 8'h04);
        $display("test calibration done");

        // every unit code; reserved 00 times as the short unit
        for (int c = 0; c < 4; c++) begin
            // rx unit walks the codes backwards so a swapped field shows
            listen_go({c[1:0], 2'(3 - c), 4'h2}, 8'h02);
            wait_mode(MODE_RX, 300);
            `CHK(n inside {[un[c] * 2 - 1 : un[c] * 2 + 3]}, 1'b1)
            wait_mode(MODE_STANDBY, 300);
            `CHK(n inside {[un[3 - c] * 2 - 1 : un[3 - c] * 2 + 3]}, 1'b1)
            wr_reg(ADDR_OPMODE, 8'h04);
        end
        $display("test listen timing done");

        // exit 01 with pattern match required
        listen_go(8'h5A, 8'h02);
        wait_mode(MODE_RX, 100);
        set_rx(4'h8);
        wait_mode(MODE_STANDBY, 20);
        wait_mode(MODE_RX, 100);
        set_rx(4'hC);
        set_rx(4'h0);
        tick(20);
        `CHK(cur_mode, MODE_RX)
        `CHK(listen_act, 1'b1)
        set_rx(4'h2);
        set_rx(4'h0);
        tick(1);
        `CHK(cur_mode, MODE_STANDBY)
        `CHK(listen_act, 1'b0)
        wr_reg(ADDR_OPMODE, 8'h04);
        $display("test exit to mode done");

        // second pass uses reserved exit 11, which stays like 00
        for (int e = 0; e < 2; e++) begin
            listen_go(e ? 8'h56 : 8'h50, 8'h02);
            wait_mode(MODE_RX, 100);
            set_rx(4'h8);
            set_rx(4'h0);
            tick(20);
            `CHK(cur_mode, MODE_RX)
            `CHK(listen_act, 1'b0)
            wr_reg(ADDR_OPMODE, 8'h04);
            tick(1);
            `CHK(cur_mode, MODE_STANDBY)
        end
        $display("test exit stay done");

        listen_go(8'h54, 8'h02);
        wait_mode(MODE_RX, 100);
        set_rx(4'h8);
        set_rx(4'h0);
        tick(12);
        `CHK(cur_mode, MODE_RX)
        set_rx(4'h1);
        set_rx(4'h0);
        tick(1);
        `CHK(cur_mode, MODE_STANDBY)
        `CHK(listen_act, 1'b1)
        n = 0;
        while (flush !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        `CHK(flush, 1'b1)
        wr_reg(ADDR_OPMODE, 8'h04);
        $display("test exit resume done");
        results();
    end
endmodule // lpc_listen_power_regs_tb_top

bind lpc_listen_power_regs lpc_listen_power_regs_monitor #(.REVISION(REVISION)) u_monitor (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .rx_status_i(rx_status_i), .cur_mode_o(cur_mode_o),
    .listen_active_o(listen_active_o), .fifo_flush_o(fifo_flush_o), .osc_cal_busy_o(osc_cal_busy_o),
    .amp_cfg_o(amp_cfg_o));
